// *** rtl/packer_defs.svh ***
`ifndef PACKER_DEFS_SVH
`define PACKER_DEFS_SVH

// ==========================================================
// Register byte offsets
`define PKR_OFS_CTRL 12'h000
`define PKR_OFS_DELIM 12'h004
`define PKR_OFS_PKTLEN 12'h008
`define PKR_OFS_FTX 12'h00C
`define PKR_OFS_STATUS 12'h010

// ==========================================================
// Control register fields
`define PKR_CTRL_DPROC_LO 0
`define PKR_CTRL_DPROC_HI 1
`define PKR_CTRL_D1_EN 2
`define PKR_CTRL_D2_EN 3
`define PKR_CTRL_JAM_IGN 4
`define PKR_CTRL_DRV_CTL 5
`define PKR_CTRL_RTS_LOW 6
`define PKR_CTRL_DTR_LOW 7
`define PKR_CTRL_MAXC_LO 8
`define PKR_CTRL_MAXC_HI 11

// Status register fields
`define PKR_STAT_CNT_HI 10
`define PKR_STAT_LINK 16
`define PKR_STAT_RTS 17
`define PKR_STAT_DTR 18

// ==========================================================
// Reset values and limits
`define PKR_MAXC_RST 4'h1
`define PKR_MAXC_TOP 4'h8
`define PKR_BUF_BYTES 1024
`define PKR_PKTLEN_MAX 11'h400

// ==========================================================
// Timing: one millisecond at a 100 ns clock
`define PKR_MS_NS 1000000
`define PKR_CLK_NS 100

`endif

// *** rtl/packer_pkg.sv ***
// ==========================================================
// Types shared by the packer files
package packer_pkg;

    typedef enum logic [1:0] {
        DPROC_NOTHING,
        DPROC_PLUS1,
        DPROC_PLUS2,
        DPROC_STRIP
    } dproc_t;

    typedef enum {
        ST_COLLECT,
        ST_FETCH,
        ST_SEND
    } pack_state_t;

endpackage : packer_pkg

// *** rtl/packer_buf_ram.sv ***
`timescale 1ns/10ps

// ==========================================================
// Byte store for one port, registered read data
module packer_buf_ram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read side
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [DEPTH];

    // No reset on the array, so it can map onto block RAM
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : packer_buf_ram

// *** rtl/serial_rx_data_packer.sv ***
`timescale 1ns/10ps
`include "packer_defs.svh"

// Notes on behaviour
// - Nonzero length: flush when count reaches it
// - Zero length: no length trigger at all
// - First delimiter match flushes the buffer
// - Second delimiter also matches when enabled
// - Without second, first delimiter alone matches
// - Full buffer always flushes automatically
// - Plus-one/plus-two defer flush by bytes
// - Strip mode drops delimiter, sends rest
// - Do-nothing mode sends upon delimiter byte
// - Zero timeout disables timer trigger
// - Timeout in ms groups bytes, flushes
// - One kilobyte buffer per serial port
// - Link down drives RTS/DTR low optionally
// - One to eight hosts; mask limits them
// - Multi-host commands need driver control enabled
// - Jam option skips stalled hosts
// - Network bytes reach serial in order
module serial_rx_data_packer #(
    parameter int MS_CYCLES = `PKR_MS_NS / `PKR_CLK_NS,
    parameter int DEPTH = `PKR_BUF_BYTES,
    parameter int HOSTS = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bytes from the serial receiver
    input wire logic ser_rx_valid,
    input wire logic [7:0] ser_rx_data,
    output logic ser_rx_ready,
    // Packed frames toward the hosts
    input wire logic [HOSTS-1:0] host_open,
    input wire logic [HOSTS-1:0] host_ready,
    output logic frm_valid,
    output logic [7:0] frm_data,
    output logic frm_last,
    output logic [HOSTS-1:0] frm_dest,
    // Network bytes toward the serial transmitter
    input wire logic net_valid,
    input wire logic [7:0] net_data,
    output logic net_ready,
    output logic ser_tx_valid,
    output logic [7:0] ser_tx_data,
    input wire logic ser_tx_ready,
    // Host control commands and modem lines
    input wire logic ctl_valid,
    input wire logic [2:0] ctl_host,
    input wire logic ctl_rts,
    input wire logic ctl_dtr,
    input wire logic link_up_pin,
    output logic ser_rts,
    output logic ser_dtr
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(MS_CYCLES + 1);

    // Host slots allowed by the connection limit
    function automatic logic [HOSTS-1:0] conn_mask(input logic [3:0] maxc);
        logic [HOSTS-1:0] m;
        m = '0;
        for (int i = 0; i < HOSTS; i++) begin
            m[i] = (4'(i) < maxc);
        end
        return m;
    endfunction : conn_mask

    // ======================================================
    // Configuration registers and APB slave
    logic [11:0] ctrl_q, ctrl_d;
    logic [15:0] delim_q, delim_d;
    logic [10:0] plen_q, plen_d;
    logic [15:0] ftx_q, ftx_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] status_w;
    logic link_ok_q;
    logic [10:0] cnt_q;
    logic rts_q, dtr_q;
    logic [3:0] maxc;
    logic [3:0] maxc_wr;
    logic mapped;
    packer_pkg::dproc_t dproc;

    assign dproc = packer_pkg::dproc_t'(ctrl_q[`PKR_CTRL_DPROC_HI:`PKR_CTRL_DPROC_LO]);
    assign maxc = ctrl_q[`PKR_CTRL_MAXC_HI:`PKR_CTRL_MAXC_LO];
    assign maxc_wr = pwdata[`PKR_CTRL_MAXC_HI:`PKR_CTRL_MAXC_LO];
    assign status_w = {13'h0000, dtr_q, rts_q, link_ok_q, 5'h00, cnt_q};
    assign mapped = (paddr == `PKR_OFS_CTRL) || (paddr == `PKR_OFS_DELIM) ||
                    (paddr == `PKR_OFS_PKTLEN) || (paddr == `PKR_OFS_FTX) ||
                    (paddr == `PKR_OFS_STATUS);

    // Answer prepared in setup, so every access ends in one access cycle
    always_comb begin
        ctrl_d = ctrl_q;
        delim_d = delim_q;
        plen_d = plen_q;
        ftx_d = ftx_q;
        prdata_d = prdata_q;
        pready_d = psel && !penable;
        pslverr_d = psel && !penable && !mapped;
        if (psel && !penable) begin
            case (paddr)
                `PKR_OFS_CTRL: prdata_d = {20'h00000, ctrl_q};
                `PKR_OFS_DELIM: prdata_d = {16'h0000, delim_q};
                `PKR_OFS_PKTLEN: prdata_d = {21'h000000, plen_q};
                `PKR_OFS_FTX: prdata_d = {16'h0000, ftx_q};
                `PKR_OFS_STATUS: prdata_d = status_w;
                default: prdata_d = 32'h00000000;
            endcase
        end
        if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                `PKR_OFS_CTRL: begin
                    ctrl_d = pwdata[11:0];
                    // Connection limit held to 1..8
                    if (maxc_wr == 4'h0) begin
                        ctrl_d[`PKR_CTRL_MAXC_HI:`PKR_CTRL_MAXC_LO] = `PKR_MAXC_RST;
                    end else if (maxc_wr > `PKR_MAXC_TOP) begin
                        ctrl_d[`PKR_CTRL_MAXC_HI:`PKR_CTRL_MAXC_LO] = `PKR_MAXC_TOP;
                    end
                end
                `PKR_OFS_DELIM: delim_d = pwdata[15:0];
                `PKR_OFS_PKTLEN: begin
                    // Lengths beyond the buffer are clamped to it
                    plen_d = (pwdata[31:0] > 32'(`PKR_PKTLEN_MAX)) ? `PKR_PKTLEN_MAX :
                             pwdata[10:0];
                end
                `PKR_OFS_FTX: ftx_d = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= {`PKR_MAXC_RST, 8'h00};
            delim_q <= 16'h0000;
            plen_q <= 11'h000;
            ftx_q <= 16'h0000;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            delim_q <= delim_d;
            plen_q <= plen_d;
            ftx_q <= ftx_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ======================================================
    // Packer: collect, then drain the buffer one byte at a time
    packer_pkg::pack_state_t st_q, st_d;
    logic [10:0] cnt_d, cnt_n;
    logic [AW-1:0] rd_q, rd_d;
    logic [1:0] pend_q, pend_d;
    logic [PW-1:0] pre_q, pre_d;
    logic [15:0] tmr_q, tmr_d;
    logic rxr_q, rxr_d, fv_q, fv_d, fl_q, fl_d;
    logic [HOSTS-1:0] dest_q, dest_d, open_w;
    logic byte_in, match, strip, wr, fire, deliver;
    logic [7:0] ram_q;

    assign open_w = host_open & conn_mask(maxc);
    assign byte_in = ser_rx_valid && rxr_q;
    // Second value is only honoured alongside the first
    assign match = ctrl_q[`PKR_CTRL_D1_EN] && ((ser_rx_data == delim_q[7:0]) ||
                   (ctrl_q[`PKR_CTRL_D2_EN] && ser_rx_data == delim_q[15:8]));
    assign strip = match && (dproc == packer_pkg::DPROC_STRIP);
    assign wr = byte_in && !strip;
    assign cnt_n = cnt_q + 11'(wr);
    // Stalled hosts are skipped only when jam ignoring is on
    assign deliver = fv_q && (ctrl_q[`PKR_CTRL_JAM_IGN] ?
                     ((|(host_ready & dest_q)) || (dest_q == '0)) :
                     (&(host_ready | ~dest_q)));

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        pend_d = pend_q;
        pre_d = pre_q;
        tmr_d = tmr_q;
        fv_d = fv_q;
        fl_d = fl_q;
        dest_d = dest_q;
        fire = 1'b0;
        case (st_q)
            packer_pkg::ST_COLLECT: begin
                if (byte_in) begin
                    cnt_d = cnt_n;
                    if (pend_q != 2'h0) begin
                        pend_d = pend_q - 2'h1;
                        fire = (pend_q == 2'h1);
                    end else if (match) begin
                        case (dproc)
                            packer_pkg::DPROC_PLUS1: pend_d = 2'h1;
                            packer_pkg::DPROC_PLUS2: pend_d = 2'h2;
                            default: fire = 1'b1;
                        endcase
                    end
                    if (plen_q != 11'h000 && cnt_n == plen_q) begin
                        fire = 1'b1;
                    end
                    if (cnt_n == 11'(DEPTH)) begin
                        fire = 1'b1;
                    end
                end
                // Interval counts from the first byte in the buffer
                if (ftx_q == 16'h0000 || cnt_d == 11'h000) begin
                    pre_d = '0;
                    tmr_d = 16'h0000;
                end else if (pre_q == PW'(MS_CYCLES - 1)) begin
                    pre_d = '0;
                    tmr_d = tmr_q + 16'h0001;
                    fire = fire || (tmr_q + 16'h0001 == ftx_q);
                end else begin
                    pre_d = pre_q + PW'(1);
                end
                if (fire) begin
                    pend_d = 2'h0;
                    pre_d = '0;
                    tmr_d = 16'h0000;
                    rd_d = '0;
                    // Empty flush, e.g. a lone stripped delimiter, sends nothing
                    if (cnt_d != 11'h000) begin
                        st_d = packer_pkg::ST_FETCH;
                    end
                end
            end
            packer_pkg::ST_FETCH: begin
                fv_d = 1'b1;
                fl_d = (11'(rd_q) == cnt_q - 11'h001);
                dest_d = open_w;
                st_d = packer_pkg::ST_SEND;
            end
            packer_pkg::ST_SEND: begin
                if (deliver) begin
                    fv_d = 1'b0;
                    fl_d = 1'b0;
                    if (fl_q) begin
                        cnt_d = 11'h000;
                        rd_d = '0;
                        st_d = packer_pkg::ST_COLLECT;
                    end else begin
                        rd_d = rd_q + AW'(1);
                        st_d = packer_pkg::ST_FETCH;
                    end
                end
            end
            default: st_d = packer_pkg::ST_COLLECT;
        endcase
        rxr_d = (st_d == packer_pkg::ST_COLLECT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= packer_pkg::ST_COLLECT;
            cnt_q <= 11'h000;
            rd_q <= '0;
            pend_q <= 2'h0;
            pre_q <= '0;
            tmr_q <= 16'h0000;
            rxr_q <= 1'b0;
            fv_q <= 1'b0;
            fl_q <= 1'b0;
            dest_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            pend_q <= pend_d;
            pre_q <= pre_d;
            tmr_q <= tmr_d;
            rxr_q <= rxr_d;
            fv_q <= fv_d;
            fl_q <= fl_d;
            dest_q <= dest_d;
        end
    end

    packer_buf_ram #(.DEPTH(DEPTH), .AW(AW)) u_buf (
        .clk(pclk),
        .wr_en(wr),
        .wr_addr(cnt_q[AW-1:0]),
        .wr_data(ser_rx_data),
        .rd_addr(rd_q),
        .rd_data(ram_q)
    );

    assign ser_rx_ready = rxr_q;
    assign frm_valid = fv_q;
    assign frm_data = ram_q;
    assign frm_last = fl_q;
    assign frm_dest = dest_q;

    // ======================================================
    // Network to serial stage, modem lines and link sync
    logic txv_q, txv_d, nr_q, nr_d;
    logic [7:0] txd_q, txd_d;
    logic crts_q, crts_d, cdtr_q, cdtr_d, rts_d, dtr_d, link_d;
    logic [2:0] lsync_q;
    logic ctl_ok;

    // Single stage keeps bytes strictly in arrival order
    assign ctl_ok = ctl_valid && ((maxc == `PKR_MAXC_RST) ? (ctl_host == 3'h0) :
                    ctrl_q[`PKR_CTRL_DRV_CTL]);
    always_comb begin
        txv_d = txv_q;
        txd_d = txd_q;
        if (txv_q && ser_tx_ready) begin
            txv_d = 1'b0;
        end
        if (net_valid && nr_q) begin
            txv_d = 1'b1;
            txd_d = net_data;
        end
        nr_d = !txv_d;
        crts_d = ctl_ok ? ctl_rts : crts_q;
        cdtr_d = ctl_ok ? ctl_dtr : cdtr_q;
        // Link state moves only once stages two and three agree
        link_d = (lsync_q[1] == lsync_q[2]) ? lsync_q[2] : link_ok_q;
        rts_d = crts_q && !(ctrl_q[`PKR_CTRL_RTS_LOW] && !link_ok_q);
        dtr_d = cdtr_q && !(ctrl_q[`PKR_CTRL_DTR_LOW] && !link_ok_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txv_q <= 1'b0;
            txd_q <= 8'h00;
            nr_q <= 1'b0;
            crts_q <= 1'b1;
            cdtr_q <= 1'b1;
            rts_q <= 1'b0;
            dtr_q <= 1'b0;
            lsync_q <= 3'h0;
            link_ok_q <= 1'b0;
        end else begin
            txv_q <= txv_d;
            txd_q <= txd_d;
            nr_q <= nr_d;
            crts_q <= crts_d;
            cdtr_q <= cdtr_d;
            rts_q <= rts_d;
            dtr_q <= dtr_d;
            lsync_q <= {lsync_q[1:0], link_up_pin};
            link_ok_q <= link_d;
        end
    end

    assign net_ready = nr_q;
    assign ser_tx_valid = txv_q;
    assign ser_tx_data = txd_q;
    assign ser_rts = rts_q;
    assign ser_dtr = dtr_q;

    // ======================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_out;
        st_q == packer_pkg::ST_SEND && deliver && fl_q;
    endsequence
    sequence s_idle_clean;
        cnt_q == 11'h000 && pend_q == 2'h0 ##0 tmr_q == 16'h0000;
    endsequence

    property p_len_flush;
        st_q == packer_pkg::ST_COLLECT && wr && plen_q != 11'h000 && cnt_n == plen_q
            |=> st_q == packer_pkg::ST_FETCH ##1 frm_valid;
    endproperty
    a_len_flush: assert property (p_len_flush) else $error("length flush missed");

    property p_full_flush;
        st_q == packer_pkg::ST_COLLECT && wr && cnt_q == 11'(DEPTH - 1)
            |=> st_q == packer_pkg::ST_FETCH && cnt_q == 11'(DEPTH);
    endproperty
    a_full_flush: assert property (p_full_flush) else $error("full flush missed");

    property p_delim_now;
        st_q == packer_pkg::ST_COLLECT && byte_in && match && pend_q == 2'h0 &&
            dproc == packer_pkg::DPROC_NOTHING |=> st_q == packer_pkg::ST_FETCH;
    endproperty
    a_delim_now: assert property (p_delim_now) else $error("delimiter flush missed");

    property p_plus2;
        st_q == packer_pkg::ST_COLLECT && byte_in && match && pend_q == 2'h0 &&
            dproc == packer_pkg::DPROC_PLUS2 && plen_q == 11'h000 && cnt_n != 11'(DEPTH) &&
            ftx_q == 16'h0000
            |=> pend_q == 2'h2 && st_q == packer_pkg::ST_COLLECT;
    endproperty
    a_plus2: assert property (p_plus2) else $error("plus two countdown wrong");

    property p_strip;
        st_q == packer_pkg::ST_COLLECT && byte_in && strip
            |=> cnt_q == $past(cnt_q) || cnt_q == 11'h000;
    endproperty
    a_strip: assert property (p_strip) else $error("stripped byte was stored");

    property p_tmo_off;
        ftx_q == 16'h0000 |=> tmr_q == 16'h0000;
    endproperty
    a_tmo_off: assert property (p_tmo_off) else $error("timer runs while disabled");

    property p_clean;
        s_last_out |=> s_idle_clean ##0 st_q == packer_pkg::ST_COLLECT;
    endproperty
    a_clean: assert property (p_clean) else $error("state left after flush");

    property p_linkdown;
        !link_ok_q && ctrl_q[`PKR_CTRL_RTS_LOW] |=> !ser_rts;
    endproperty
    a_linkdown: assert property (p_linkdown) else $error("rts high with link down");

    property p_fifo;
        net_valid && net_ready |=> ser_tx_valid && ser_tx_data == $past(net_data);
    endproperty
    a_fifo: assert property (p_fifo) else $error("network byte lost");

    property p_ctl_ignored;
        ctl_valid && maxc != `PKR_MAXC_RST && !ctrl_q[`PKR_CTRL_DRV_CTL] |=> $stable(crts_q);
    endproperty
    a_ctl_ignored: assert property (p_ctl_ignored) else $error("command taken");

endmodule : serial_rx_data_packer

// *** tb/packer_peer.sv ***
`timescale 1ns/10ps

// ========
// Serial device and network hosts stand-in
module packer_peer (
    // Clock
    input wire logic pclk,
    // Serial device toward the packer
    output logic ser_rx_valid,
    output logic [7:0] ser_rx_data,
    input wire logic ser_rx_ready,
    // Hosts taking frames
    input wire logic frm_valid,
    input wire logic [7:0] frm_data,
    input wire logic frm_last,
    input wire logic [7:0] frm_dest,
    output logic [7:0] host_ready,
    // Serial transmitter sink
    input wire logic ser_tx_valid,
    input wire logic [7:0] ser_tx_data,
    output logic ser_tx_ready
);
    logic [7:0] got[$];
    logic [7:0] txq[$];
    int frames = 0;
    logic stall = 1'b0;

    initial begin
        ser_rx_valid = 1'b0;
        ser_rx_data = 8'h00;
    end

    // Hosts stall only when a scenario asks for it
    assign host_ready = stall ? 8'h00 : 8'hFF;
    assign ser_tx_ready = 1'b1;

    // One byte held until taken; idle data inverted so no stale value lingers
    task automatic send(input logic [7:0] b);
        @(posedge pclk);
        ser_rx_valid <= 1'b1;
        ser_rx_data <= b;
        do @(posedge pclk); while (ser_rx_ready !== 1'b1);
        ser_rx_valid <= 1'b0;
        ser_rx_data <= ~b;
    endtask : send

    // A byte counts only when every addressed host takes it
    always @(posedge pclk) begin
        if (frm_valid === 1'b1 && (frm_dest & host_ready) === frm_dest) begin
            got.push_back(frm_data);
            if (frm_last === 1'b1) frames++;
        end
        if (ser_tx_valid === 1'b1) txq.push_back(ser_tx_data);
    end
endmodule : packer_peer

// *** tb/test_serial_rx_data_packer.sv ***
`timescale 1ns/10ps
`include "packer_defs.svh"

// ========
// Bench for the receive packer
module test_serial_rx_data_packer;
    localparam int MSC = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, err_q;
    logic ser_rx_valid, ser_rx_ready, frm_valid, frm_last, net_ready, ser_tx_valid;
    logic ser_tx_ready, ser_rts, ser_dtr;
    logic [7:0] ser_rx_data, host_ready, frm_data, frm_dest, ser_tx_data;
    logic net_valid = 1'b0;
    logic [7:0] net_data = 8'h00;
    logic ctl_valid = 1'b0;
    logic ctl_rts = 1'b1;
    logic link_up_pin = 1'b1;
    logic [7:0] host_open = 8'hFF;
    logic [7:0] big[$];
    int err_count = 0;
    int checked = 0;
    int nf = 0;

    // 100 ns period
    always #50 pclk = ~pclk;

    serial_rx_data_packer #(.MS_CYCLES(MSC)) serial_rx_data_packer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_rx_valid(ser_rx_valid),
        .ser_rx_data(ser_rx_data), .ser_rx_ready(ser_rx_ready),
        .host_open(host_open), .host_ready(host_ready), .frm_valid(frm_valid),
        .frm_data(frm_data), .frm_last(frm_last), .frm_dest(frm_dest),
        .net_valid(net_valid), .net_data(net_data), .net_ready(net_ready),
        .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
        .ser_tx_ready(ser_tx_ready), .ctl_valid(ctl_valid), .ctl_host(3'h0),
        .ctl_rts(ctl_rts), .ctl_dtr(1'b1), .link_up_pin(link_up_pin),
        .ser_rts(ser_rts), .ser_dtr(ser_dtr)
    );

    packer_peer peer_inst (
        .pclk(pclk), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
        .ser_rx_ready(ser_rx_ready), .frm_valid(frm_valid), .frm_data(frm_data),
        .frm_last(frm_last), .frm_dest(frm_dest), .host_ready(host_ready),
        .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
        .ser_tx_ready(ser_tx_ready)
    );

    // ========
    // Tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd_q, exp);
    endtask : rd

    task automatic sendq(input logic [7:0] s[$]);
        foreach (s[i]) peer_inst.send(s[i]);
    endtask : sendq

    // Bounded wait for the next whole frame, then byte-wise compare
    task automatic frame(input logic [7:0] e[$]);
        int k;
        k = 0;
        while (peer_inst.frames == nf && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        nf = peer_inst.frames;
        cmp(32'(peer_inst.got.size()), 32'(e.size()));
        foreach (e[i]) cmp(32'(peer_inst.got[i]), 32'(e[i]));
        peer_inst.got.delete();
    endtask : frame

    task automatic pulse(input logic r);
        @(posedge pclk);
        ctl_valid <= 1'b1;
        ctl_rts <= r;
        @(posedge pclk);
        ctl_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // ========
    // Scenarios
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PKR_OFS_CTRL, 32'h0000_0100);
        rd(`PKR_OFS_PKTLEN, 32'h0);
        rd(`PKR_OFS_FTX, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        cmp(32'(err_q), 32'h1);
        wr(`PKR_OFS_PKTLEN, 32'h0000_0FFF);
        rd(`PKR_OFS_PKTLEN, 32'h0000_0400);
        wr(`PKR_OFS_CTRL, 32'h0000_0F00);
        rd(`PKR_OFS_CTRL, 32'h0000_0800);
        wr(`PKR_OFS_PKTLEN, 32'h0);
        done("registers");
        // Second delimiter value present but disabled at first
        wr(`PKR_OFS_DELIM, 32'h0000_0A0D);
        wr(`PKR_OFS_CTRL, 32'h0000_0104);
        sendq('{8'h41, 8'h0A, 8'h0D});
        frame('{8'h41, 8'h0A, 8'h0D});
        cmp(32'(frm_dest), 32'h1);
        wr(`PKR_OFS_CTRL, 32'h0000_010C);
        sendq('{8'h42, 8'h0A});
        frame('{8'h42, 8'h0A});
        wr(`PKR_OFS_CTRL, 32'h0000_0107);
        sendq('{8'h43, 8'h44, 8'h0D});
        frame('{8'h43, 8'h44});
        wr(`PKR_OFS_CTRL, 32'h0000_0106);
        sendq('{8'h0D, 8'h45, 8'h46, 8'h47});
        frame('{8'h0D, 8'h45, 8'h46});
        rd(`PKR_OFS_STATUS, 32'h0007_0001);
        wr(`PKR_OFS_CTRL, 32'h0000_0105);
        sendq('{8'h0D, 8'h48});
        frame('{8'h47, 8'h0D, 8'h48});
        done("delimiters");
        wr(`PKR_OFS_CTRL, 32'h0000_0300);
        wr(`PKR_OFS_PKTLEN, 32'h3);
        sendq('{8'h0D, 8'h01, 8'h02});
        frame('{8'h0D, 8'h01, 8'h02});
        wr(`PKR_OFS_PKTLEN, 32'h0);
        wr(`PKR_OFS_FTX, 32'h0000_000B);
        sendq('{8'h49});
        frame('{8'h49});
        wr(`PKR_OFS_FTX, 32'h0);
        done("length and timeout");
        // Idle byte must stay; then fill to capacity with hosts stalled
        host_open <= 8'hFB;
        big.push_back(8'h4A);
        peer_inst.send(8'h4A);
        repeat (300) @(posedge pclk);
        cmp(32'(peer_inst.frames), 32'(nf));
        peer_inst.stall <= 1'b1;
        for (int i = 1; i < `PKR_BUF_BYTES; i++) begin
            big.push_back(8'(i));
            peer_inst.send(8'(i));
        end
        repeat (20) @(posedge pclk);
        peer_inst.stall <= 1'b0;
        frame(big);
        cmp(32'(frm_dest), 32'h3);
        rd(`PKR_OFS_STATUS, 32'h0007_0000);
        done("full buffer");
        // Network bytes back to back
        for (int i = 0; i < 4; i++) begin
            net_valid <= 1'b1;
            net_data <= 8'hC0 + 8'(i);
            do @(posedge pclk); while (net_ready !== 1'b1);
        end
        net_valid <= 1'b0;
        repeat (4) @(posedge pclk);
        cmp(32'(peer_inst.txq.size()), 32'h4);
        foreach (peer_inst.txq[i]) cmp(32'(peer_inst.txq[i]), 32'hC0 + i);
        done("network order");
        wr(`PKR_OFS_CTRL, 32'h0000_0240);
        pulse(1'b0);
        cmp(32'(ser_rts), 32'h1);
        wr(`PKR_OFS_CTRL, 32'h0000_0260);
        pulse(1'b0);
        cmp(32'(ser_rts), 32'h0);
        pulse(1'b1);
        link_up_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        cmp(32'(ser_rts), 32'h0);
        cmp(32'(ser_dtr), 32'h1);
        done("control lines");
        stop_test();
    end

    // Whole run needs well under 10000 cycles; allow twice that
    initial begin
        #2000000;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : test_serial_rx_data_packer
